// File: dtp_timer_pair.sv
// Dual 16-bit / paired 32-bit timer with APB registers, pin sync and interrupt.
// Assumes one pclk domain; cpu_idle_i is a same-clock level from the power controller.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module dtp_timer_pair (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins and system
  input wire logic external_clock_gate_pin,
  input wire logic high_clock_gate_pin,
  input wire logic cpu_idle_i,
  // Events
  output logic irq_o,
  output logic adc_trigger_o
);

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] low_word_count_q;
  logic [15:0] high_word_count_q;
  logic [15:0] upper_word_hold_q;
  logic [15:0] low_period_value_q;
  logic [15:0] high_period_value_q;
  logic [15:0] low_timer_control_q;
  logic [15:0] high_timer_control_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;

  // ****************************************
  // Bus decode
  // ****************************************
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic hit;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  // Read decoded in the setup cycle, the edge at which prdata is loaded
  assign rd = psel && !penable && !pwrite;
  assign addr = paddr & dtp_pkg::DTP_ADDR_MASK;
  assign hit = (addr <= dtp_pkg::DTP_IRQ_MASK_OFS);

  logic wr_lcnt;
  logic wr_hcnt;
  logic wr_lctl;
  logic wr_hctl;
  assign wr_lcnt = wr && addr == dtp_pkg::DTP_LOW_COUNT_OFS;
  assign wr_hcnt = wr && addr == dtp_pkg::DTP_HIGH_COUNT_OFS;
  assign wr_lctl = wr && addr == dtp_pkg::DTP_LOW_CTRL_OFS;
  assign wr_hctl = wr && addr == dtp_pkg::DTP_HIGH_CTRL_OFS;

  // ****************************************
  // Control decode
  // ****************************************
  logic paired;
  logic [15:0] hctl;
  assign paired = low_timer_control_q[dtp_pkg::DTP_PAIR_BIT];
  assign hctl = paired ? low_timer_control_q : high_timer_control_q;

  // Enable per half: on, not stopped by idle, and gate high in gated mode
  function automatic logic half_run(input logic [15:0] c, input logic idle,
                                    input logic gate);
    logic on;
    on = c[dtp_pkg::DTP_TIMER_ON_BIT];
    if (idle && c[dtp_pkg::DTP_STOP_IDLE_BIT]) begin
      on = 1'b0;
    end
    if (c[dtp_pkg::DTP_GATE_BIT] && !c[dtp_pkg::DTP_CLKSRC_BIT] && !gate) begin
      on = 1'b0;
    end
    half_run = on;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic lpin_lvl;
  logic lpin_rise;
  logic lpin_fall;
  logic hpin_lvl;
  logic hpin_rise;
  logic hpin_fall;

  dtp_pin_sync u_lsync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_i(external_clock_gate_pin),
    .level_o(lpin_lvl),
    .rise_o(lpin_rise),
    .fall_o(lpin_fall)
  );

  // High pin only serves the unpaired high half; paired uses the low pin
  dtp_pin_sync u_hsync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_i(high_clock_gate_pin),
    .level_o(hpin_lvl),
    .rise_o(hpin_rise),
    .fall_o(hpin_fall)
  );

  logic h_gate_lvl;
  logic h_gate_rise;
  logic h_gate_fall;
  assign h_gate_lvl = paired ? lpin_lvl : hpin_lvl;
  assign h_gate_rise = paired ? lpin_rise : hpin_rise;
  assign h_gate_fall = paired ? lpin_fall : hpin_fall;

  logic l_run;
  logic h_run;
  logic l_src;
  logic h_src;
  assign l_run = half_run(low_timer_control_q, cpu_idle_i, lpin_lvl);
  assign h_run = half_run(hctl, cpu_idle_i, h_gate_lvl);
  // Counter mode uses pin rising edges; there is no asynchronous counter path
  assign l_src = low_timer_control_q[dtp_pkg::DTP_CLKSRC_BIT] ? lpin_rise : 1'b1;
  assign h_src = hctl[dtp_pkg::DTP_CLKSRC_BIT] ? h_gate_rise : 1'b1;

  // ****************************************
  // Prescalers
  // ****************************************
  logic l_tick_raw;
  logic h_tick;
  logic l_tick_q;
  logic l_clr;
  logic h_clr;
  assign l_clr = wr_lcnt || wr_lctl || !low_timer_control_q[dtp_pkg::DTP_TIMER_ON_BIT];
  assign h_clr = wr_hcnt || wr_hctl;

  dtp_prescaler #(.WIDTH(dtp_pkg::DTP_PRESC_W)) u_lpre (
    .pclk(pclk),
    .presetn(presetn),
    .clear_i(l_clr),
    .sel_i(low_timer_control_q[dtp_pkg::DTP_PRESC_HI_BIT:dtp_pkg::DTP_PRESC_LO_BIT]),
    .tick_i(l_run && l_src),
    .tick_o(l_tick_raw)
  );

  dtp_prescaler #(.WIDTH(dtp_pkg::DTP_PRESC_W)) u_hpre (
    .pclk(pclk),
    .presetn(presetn),
    .clear_i(h_clr),
    .sel_i(high_timer_control_q[dtp_pkg::DTP_PRESC_HI_BIT:dtp_pkg::DTP_PRESC_LO_BIT]),
    .tick_i(h_run && h_src),
    .tick_o(h_tick)
  );

  // Low prescaler output is re-timed by a flop; costs one cycle of latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      l_tick_q <= 1'b0;
    end else begin
      l_tick_q <= l_tick_raw && !l_clr;
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  logic [31:0] cnt32;
  logic [31:0] per32;
  logic match32;
  logic lmatch;
  logic hmatch;
  logic h_step;
  assign cnt32 = {high_word_count_q, low_word_count_q};
  assign per32 = {high_period_value_q, low_period_value_q};
  assign match32 = paired && l_tick_q && (cnt32 == per32);
  assign lmatch = !paired && l_tick_q && (low_word_count_q == low_period_value_q);
  assign h_step = !paired && h_tick;
  assign hmatch = h_step && (high_word_count_q == high_period_value_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_word_count_q <= dtp_pkg::DTP_COUNT_RST;
    end else if (wr_lcnt) begin
      low_word_count_q <= pwdata[15:0];
    end else if (match32 || lmatch) begin
      low_word_count_q <= dtp_pkg::DTP_COUNT_RST;
    end else if (l_tick_q) begin
      low_word_count_q <= low_word_count_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_word_count_q <= dtp_pkg::DTP_COUNT_RST;
    end else if (wr_lcnt && paired) begin
      high_word_count_q <= upper_word_hold_q;
    end else if (wr_hcnt) begin
      high_word_count_q <= pwdata[15:0];
    end else if (match32 || hmatch) begin
      high_word_count_q <= dtp_pkg::DTP_COUNT_RST;
    end else if (paired && l_tick_q && low_word_count_q == 16'hFFFF) begin
      high_word_count_q <= high_word_count_q + 16'h0001;
    end else if (h_step) begin
      high_word_count_q <= high_word_count_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_word_hold_q <= dtp_pkg::DTP_COUNT_RST;
    end else if (rd && addr == dtp_pkg::DTP_LOW_COUNT_OFS) begin
      upper_word_hold_q <= high_word_count_q;
    end else if (wr && addr == dtp_pkg::DTP_HOLD_OFS) begin
      upper_word_hold_q <= pwdata[15:0];
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_period_value_q <= dtp_pkg::DTP_PERIOD_RST;
      high_period_value_q <= dtp_pkg::DTP_PERIOD_RST;
      low_timer_control_q <= dtp_pkg::DTP_CTRL_RST;
      high_timer_control_q <= dtp_pkg::DTP_CTRL_RST;
      irq_mask_q <= '0;
    end else if (wr) begin
      case (addr)
        dtp_pkg::DTP_LOW_PERIOD_OFS: low_period_value_q <= pwdata[15:0];
        dtp_pkg::DTP_HIGH_PERIOD_OFS: high_period_value_q <= pwdata[15:0];
        dtp_pkg::DTP_LOW_CTRL_OFS: low_timer_control_q <= pwdata[15:0] & dtp_pkg::DTP_CTRL_WMASK;
        dtp_pkg::DTP_HIGH_CTRL_OFS: begin
          // Pair bit exists only in the low control register
          high_timer_control_q <= pwdata[15:0] & dtp_pkg::DTP_CTRL_WMASK & 16'hFFF7;
        end
        dtp_pkg::DTP_IRQ_MASK_OFS: irq_mask_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Interrupts and trigger
  // ****************************************
  logic l_gate_mode;
  logic h_gate_mode;
  logic [1:0] ev;
  assign l_gate_mode = low_timer_control_q[dtp_pkg::DTP_TIMER_ON_BIT] &&
                       low_timer_control_q[dtp_pkg::DTP_GATE_BIT] &&
                       !low_timer_control_q[dtp_pkg::DTP_CLKSRC_BIT];
  assign h_gate_mode = hctl[dtp_pkg::DTP_TIMER_ON_BIT] && hctl[dtp_pkg::DTP_GATE_BIT] &&
                       !hctl[dtp_pkg::DTP_CLKSRC_BIT];
  assign ev[dtp_pkg::DTP_IRQ_LOW_BIT] = lmatch || (!paired && l_gate_mode && lpin_fall);
  // Paired events land on the high flag only
  assign ev[dtp_pkg::DTP_IRQ_HIGH_BIT] = match32 || hmatch ||
                                        (h_gate_mode && h_gate_fall);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
    end else begin
      // Set beats a same-cycle write-one clear
      irq_status_q <= (irq_status_q &
                      ~((wr && addr == dtp_pkg::DTP_IRQ_STATUS_OFS) ? pwdata[1:0] : 2'h0))
                      | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_o <= 1'b0;
      adc_trigger_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_q & irq_mask_q);
      adc_trigger_o <= match32 || hmatch;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        case (addr)
          dtp_pkg::DTP_LOW_COUNT_OFS: prdata <= {16'h0000, low_word_count_q};
          dtp_pkg::DTP_HIGH_COUNT_OFS: prdata <= {16'h0000, high_word_count_q};
          dtp_pkg::DTP_HOLD_OFS: prdata <= {16'h0000, upper_word_hold_q};
          dtp_pkg::DTP_LOW_PERIOD_OFS: prdata <= {16'h0000, low_period_value_q};
          dtp_pkg::DTP_HIGH_PERIOD_OFS: prdata <= {16'h0000, high_period_value_q};
          dtp_pkg::DTP_LOW_CTRL_OFS: prdata <= {16'h0000, low_timer_control_q};
          dtp_pkg::DTP_HIGH_CTRL_OFS: prdata <= {16'h0000, high_timer_control_q};
          dtp_pkg::DTP_IRQ_STATUS_OFS: prdata <= {30'h00000000, irq_status_q};
          dtp_pkg::DTP_IRQ_MASK_OFS: prdata <= {30'h00000000, irq_mask_q};
          default: prdata <= '0;
        endcase
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  wrap_paired_a: assert property (@(posedge pclk) disable iff (!presetn)
    match32 && !wr_lcnt && !wr_hcnt |=>
    low_word_count_q == 16'h0000 && high_word_count_q == 16'h0000)
    else $error("paired count did not wrap to zero");
  hold_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && addr == dtp_pkg::DTP_LOW_COUNT_OFS |=> upper_word_hold_q == $past(high_word_count_q))
    else $error("hold missed upper word");
  hold_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_lcnt && paired |=> high_word_count_q == $past(upper_word_hold_q))
    else $error("upper word not loaded from hold");
  idle_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_idle_i && low_timer_control_q[dtp_pkg::DTP_STOP_IDLE_BIT] && !wr_lcnt && !l_tick_q
    |=> $stable(low_word_count_q))
    else $error("count moved while idle");
  gate_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    l_gate_mode && !lpin_lvl |=> !l_tick_q)
    else $error("gated count ran with gate low");
  trig_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    adc_trigger_o |-> $past(match32) || $past(hmatch))
    else $error("trigger without a match");
  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev[dtp_pkg::DTP_IRQ_HIGH_BIT] |=> irq_status_q[dtp_pkg::DTP_IRQ_HIGH_BIT])
    else $error("high flag not set");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq_o == $past(|(irq_status_q & irq_mask_q)))
    else $error("interrupt does not track masked status");
  sync_lag_a: assert property (@(posedge pclk) disable iff (!presetn)
    l_tick_q |-> $past(l_tick_raw))
    else $error("low tick not retimed");

endmodule

// File: dtp_pkg.sv
// Package for the dual 16/32-bit timer pair: register map, control fields, reset values.
// Assumes an APB slave with 32-bit data; each register takes one aligned word.
package dtp_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] DTP_LOW_COUNT_OFS = 8'h00;
  localparam logic [7:0] DTP_HIGH_COUNT_OFS = 8'h04;
  localparam logic [7:0] DTP_HOLD_OFS = 8'h08;
  localparam logic [7:0] DTP_LOW_PERIOD_OFS = 8'h0C;
  localparam logic [7:0] DTP_HIGH_PERIOD_OFS = 8'h10;
  localparam logic [7:0] DTP_LOW_CTRL_OFS = 8'h14;
  localparam logic [7:0] DTP_HIGH_CTRL_OFS = 8'h18;
  localparam logic [7:0] DTP_IRQ_STATUS_OFS = 8'h1C;
  localparam logic [7:0] DTP_IRQ_MASK_OFS = 8'h20;
  localparam logic [7:0] DTP_ADDR_MASK = 8'hFC;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int DTP_TIMER_ON_BIT = 15;
  localparam int DTP_STOP_IDLE_BIT = 13;
  localparam int DTP_GATE_BIT = 6;
  localparam int DTP_PRESC_HI_BIT = 5;
  localparam int DTP_PRESC_LO_BIT = 4;
  localparam int DTP_PAIR_BIT = 3;
  localparam int DTP_CLKSRC_BIT = 1;
  localparam logic [15:0] DTP_CTRL_WMASK = 16'hA07A;

  // ****************************************
  // Interrupt status bits
  // ****************************************
  localparam int DTP_IRQ_LOW_BIT = 0;
  localparam int DTP_IRQ_HIGH_BIT = 1;
  localparam int DTP_IRQ_W = 2;

  // ****************************************
  // Reset values and prescale counts
  // ****************************************
  localparam logic [15:0] DTP_COUNT_RST = 16'h0000;
  localparam logic [15:0] DTP_PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] DTP_CTRL_RST = 16'h0000;
  localparam int DTP_PRESC_W = 8;
  localparam logic [7:0] DTP_DIV1_LAST = 8'h00;
  localparam logic [7:0] DTP_DIV8_LAST = 8'h07;
  localparam logic [7:0] DTP_DIV64_LAST = 8'h3F;
  localparam logic [7:0] DTP_DIV256_LAST = 8'hFF;

  // Terminal count of the prescaler for a two-bit select
  function automatic logic [7:0] presc_last(input logic [1:0] sel);
    case (sel)
      2'h0: presc_last = DTP_DIV1_LAST;
      2'h1: presc_last = DTP_DIV8_LAST;
      2'h2: presc_last = DTP_DIV64_LAST;
      default: presc_last = DTP_DIV256_LAST;
    endcase
  endfunction

endpackage

// File: dtp_pin_sync.sv
// Three-stage synchroniser for the external clock/gate pin with rise and fall pulses.
// Assumes the pin is asynchronous to pclk; output changes once stages two and three agree.
`timescale 1ns/1ps
module dtp_pin_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and results
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level follows only when the two later stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      rise_o <= (s2_q == s3_q) && s3_q && !level_o;
      fall_o <= (s2_q == s3_q) && !s3_q && level_o;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end

endmodule

// File: dtp_prescaler.sv
// Prescaler dividing a count-enable by 1, 8, 64 or 256.
// Assumes tick_i is a pclk-domain count enable, high in each cycle that counts; clear_i resets the divider.
`timescale 1ns/1ps
module dtp_prescaler #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clear_i,
  input wire logic [1:0] sel_i,
  input wire logic tick_i,
  // Divided output
  output logic tick_o
);

  logic [WIDTH-1:0] cnt_q;
  logic at_last;

  assign at_last = (cnt_q == WIDTH'(dtp_pkg::presc_last(sel_i)));
  assign tick_o = tick_i && at_last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (clear_i) begin
      cnt_q <= '0;
    end else if (tick_i) begin
      cnt_q <= at_last ? '0 : cnt_q + WIDTH'(1);
    end
  end

endmodule

// File: dtp_pin_source.sv
// Pin source model for the timer pair's external clock/gate pins.
// Assumes one pclk domain; bursts are slow enough for a three-flop synchroniser.
`timescale 1ns/1ps
module dtp_pin_source (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands
  input wire logic start_i,
  input wire logic [9:0] pulses_i,
  input wire logic level_i,
  // Pin
  output logic pin_o,
  output logic busy_o
);
  // ****************************************
  // Burst generator
  // ****************************************
  logic [9:0] left_q;
  logic [1:0] ph_q;
  logic pin_q;

  // Three cycles high, three low; the clock stands low between bursts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q <= 10'h000;
      ph_q <= 2'h0;
      pin_q <= 1'b0;
    end else if (start_i) begin
      left_q <= pulses_i;
      ph_q <= 2'h0;
    end else if (left_q != 10'h000) begin
      ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      if (ph_q == 2'h2) begin
        pin_q <= ~pin_q;
        if (pin_q) begin
          left_q <= left_q - 10'h001;
        end
      end
    end
  end

  // Outside bursts the pin carries the gate level
  assign busy_o = (left_q != 10'h000);
  assign pin_o = busy_o ? pin_q : level_i;
endmodule

// File: test_dual_16_or_32bit_timer_pair.sv
// Self-checking bench for the timer pair: APB master, pin sources, random counts.
// Assumes zero-wait APB answers and pin edges seen a few pclk after they occur.
`timescale 1ns/1ps
module test_dual_16_or_32bit_timer_pair;
  logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, a, h, l;
  logic cpu_idle, irq_o, adc_trigger_o, pin_a, pin_b, st_a, st_b, busy_a, busy_b;
  logic lvl_a, lvl_b, e;
  logic [9:0] k_q;
  int errors = 0, num_checks = 0, adc_n = 0, cycles = 0, s, k, seed;
  localparam logic [31:0] C_ON = 32'h1 << dtp_pkg::DTP_TIMER_ON_BIT;
  localparam logic [31:0] C_IDLE = 32'h1 << dtp_pkg::DTP_STOP_IDLE_BIT;
  localparam logic [31:0] C_GATE = 32'h1 << dtp_pkg::DTP_GATE_BIT;
  localparam logic [31:0] C_PAIR = 32'h1 << dtp_pkg::DTP_PAIR_BIT;
  localparam logic [31:0] C_EXT = 32'h1 << dtp_pkg::DTP_CLKSRC_BIT;

  always #5 pclk = ~pclk;

  dtp_timer_pair dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_clock_gate_pin(pin_a), .high_clock_gate_pin(pin_b),
    .cpu_idle_i(cpu_idle), .irq_o(irq_o), .adc_trigger_o(adc_trigger_o));
  dtp_pin_source src_a (.pclk(pclk), .presetn(presetn), .start_i(st_a), .pulses_i(k_q),
    .level_i(lvl_a), .pin_o(pin_a), .busy_o(busy_a));
  dtp_pin_source src_b (.pclk(pclk), .presetn(presetn), .start_i(st_b), .pulses_i(k_q),
    .level_i(lvl_b), .pin_o(pin_b), .busy_o(busy_b));

  // ****************************************
  // Monitors and hang guard
  // ****************************************
  always @(posedge pclk) begin
    if (adc_trigger_o === 1'b1) adc_n <= adc_n + 1;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      close_out();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask

  task automatic rd(input logic [7:0] ad);
    apb(1'b0, ad, 32'h0);
  endtask

  // Pair write order: hold first, then low word
  task automatic zero_pair();
    wr(dtp_pkg::DTP_HOLD_OFS, 32'h0);
    wr(dtp_pkg::DTP_LOW_COUNT_OFS, 32'h0);
  endtask

  task automatic burst(input logic hi, input int n);
    @(posedge pclk);
    k_q <= n[9:0];
    if (hi) st_b <= 1'b1;
    else st_a <= 1'b1;
    @(posedge pclk);
    st_a <= 1'b0;
    st_b <= 1'b0;
    @(posedge pclk);
    while (busy_a | busy_b) begin
      @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
  endtask

  function automatic int divisor(input int sel);
    return (sel == 0) ? 1 : (sel == 1) ? 8 : (sel == 2) ? 64 : 256;
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {cpu_idle, st_a, st_b, k_q, lvl_a, lvl_b} = '0;
    seed = $urandom(32'h56660368);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (s = 0; s <= 32; s += 4) begin
      rd(8'(s));
      check(r, (s == 12 || s == 16) ? 32'h0000FFFF : 32'h0, "reset value");
    end
    rd(8'h24);
    check({31'h0, e}, 32'h1, "unmapped error");
    check(r, 32'h0, "unmapped data");
    $display("test reset done");
    h = $urandom;
    l = $urandom;
    wr(dtp_pkg::DTP_LOW_CTRL_OFS, C_PAIR);
    wr(dtp_pkg::DTP_HOLD_OFS, {16'h0, h[15:0]});
    wr(dtp_pkg::DTP_LOW_COUNT_OFS, {16'h0, l[15:0]});
    rd(dtp_pkg::DTP_HIGH_COUNT_OFS);
    check(r, {16'h0, h[15:0]}, "upper word load");
    wr(dtp_pkg::DTP_HOLD_OFS, {16'h0, ~h[15:0]});
    rd(dtp_pkg::DTP_LOW_COUNT_OFS);
    check(r, {16'h0, l[15:0]}, "lower word");
    rd(dtp_pkg::DTP_HOLD_OFS);
    check(r, {16'h0, h[15:0]}, "upper capture");
    $display("test coherent done");
    for (s = 0; s < 4; s++) begin
      k = divisor(s) * (1 + $urandom_range(0, 2)) + $urandom_range(0, divisor(s) - 1);
      wr(dtp_pkg::DTP_LOW_CTRL_OFS, C_PAIR);
      zero_pair();
      wr(dtp_pkg::DTP_LOW_CTRL_OFS, C_ON | C_PAIR | C_EXT | (s << 4));
      burst(1'b0, k);
      rd(dtp_pkg::DTP_LOW_COUNT_OFS);
      check(r, k / divisor(s), "prescaled count");
    end
    $display("test prescale done");
    wr(dtp_pkg::DTP_LOW_CTRL_OFS, C_PAIR);
    zero_pair();
    wr(dtp_pkg::DTP_LOW_CTRL_OFS, C_ON | C_PAIR | C_EXT | C_IDLE);
    cpu_idle <= 1'b1;
    burst(1'b0, 5);
    rd(dtp_pkg::DTP_LOW_COUNT_OFS);
    check(r, 32'h0, "idle halt");
    cpu_idle <= 1'b0;
    burst(1'b0, 5);
    rd(dtp_pkg::DTP_LOW_COUNT_OFS);
    check(r, 32'h5, "idle resume");
    wr(dtp_pkg::DTP_LOW_CTRL_OFS, C_ON | C_PAIR | C_EXT);
    cpu_idle <= 1'b1;
    burst(1'b0, 4);
    cpu_idle <= 1'b0;
    rd(dtp_pkg::DTP_LOW_COUNT_OFS);
    check(r, 32'h9, "idle run");
    $display("test idle done");
    wr(dtp_pkg::DTP_LOW_CTRL_OFS, C_PAIR);
    zero_pair();
    wr(dtp_pkg::DTP_LOW_PERIOD_OFS, 32'h3);
    wr(dtp_pkg::DTP_HIGH_PERIOD_OFS, 32'h0);
    wr(dtp_pkg::DTP_IRQ_STATUS_OFS, 32'h3);
    adc_n = 0;
    wr(dtp_pkg::DTP_LOW_CTRL_OFS, C_ON | C_PAIR | C_EXT);
    burst(1'b0, 10);
    rd(dtp_pkg::DTP_LOW_COUNT_OFS);
    check(r, 32'h2, "paired wrap");
    check(adc_n, 2, "trigger count");
    rd(dtp_pkg::DTP_IRQ_STATUS_OFS);
    check(r, 32'h2, "high flag");
    check({31'h0, irq_o}, 32'h0, "masked irq");
    wr(dtp_pkg::DTP_IRQ_MASK_OFS, 32'h2);
    repeat (2) @(posedge pclk);
    check({31'h0, irq_o}, 32'h1, "irq raised");
    wr(dtp_pkg::DTP_IRQ_STATUS_OFS, 32'h2);
    repeat (2) @(posedge pclk);
    check({31'h0, irq_o}, 32'h0, "irq cleared");
    $display("test wrap done");
    wr(dtp_pkg::DTP_LOW_CTRL_OFS, C_PAIR);
    zero_pair();
    wr(dtp_pkg::DTP_LOW_PERIOD_OFS, 32'h9);
    wr(dtp_pkg::DTP_LOW_CTRL_OFS, C_ON | C_PAIR);
    k = 0;
    while (irq_o !== 1'b1 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    check({31'h0, irq_o}, 32'h1, "timer match irq");
    repeat (37) @(posedge pclk);
    wr(dtp_pkg::DTP_LOW_CTRL_OFS, C_PAIR);
    rd(dtp_pkg::DTP_LOW_COUNT_OFS);
    check({31'h0, r <= 32'h9}, 32'h1, "timer bounded");
    wr(dtp_pkg::DTP_IRQ_STATUS_OFS, 32'h3);
    zero_pair();
    wr(dtp_pkg::DTP_HIGH_CTRL_OFS, C_ON);
    repeat (30) @(posedge pclk);
    rd(dtp_pkg::DTP_LOW_COUNT_OFS);
    check(r, 32'h0, "high ctrl ignored");
    rd(dtp_pkg::DTP_HIGH_COUNT_OFS);
    check(r, 32'h0, "high ctrl ignored upper");
    wr(dtp_pkg::DTP_HIGH_CTRL_OFS, 32'h0);
    $display("test timer done");
    wr(dtp_pkg::DTP_LOW_PERIOD_OFS, 32'hFFFF);
    wr(dtp_pkg::DTP_LOW_CTRL_OFS, C_ON | C_PAIR | C_GATE);
    lvl_a <= 1'b1;
    repeat (40) @(posedge pclk);
    lvl_a <= 1'b0;
    repeat (12) @(posedge pclk);
    rd(dtp_pkg::DTP_LOW_COUNT_OFS);
    a = r;
    repeat (20) @(posedge pclk);
    rd(dtp_pkg::DTP_LOW_COUNT_OFS);
    check(r, a, "gate hold");
    check({31'h0, a >= 36 && a <= 44}, 32'h1, "gate span");
    rd(dtp_pkg::DTP_IRQ_STATUS_OFS);
    check(r, 32'h2, "gate fall flag");
    $display("test gate done");
    wr(dtp_pkg::DTP_LOW_CTRL_OFS, 32'h0);
    wr(dtp_pkg::DTP_IRQ_STATUS_OFS, 32'h3);
    k = 2 + $urandom_range(0, 6);
    wr(dtp_pkg::DTP_HIGH_PERIOD_OFS, k - 1);
    wr(dtp_pkg::DTP_HIGH_COUNT_OFS, 32'h0);
    adc_n = 0;
    wr(dtp_pkg::DTP_HIGH_CTRL_OFS, C_ON | C_EXT);
    burst(1'b1, 2 * k + 1);
    rd(dtp_pkg::DTP_HIGH_COUNT_OFS);
    check(r, 32'h1, "high half count");
    check(adc_n, 2, "high trigger");
    $display("test high half done");
    close_out();
  end
endmodule
